// ===== design/capability_and_brownout_ctrl.sv
// APB register bank with capability words and brown-out signalling control
//
// Notes on behaviour
// - Second capability word flags comparator, timers, serials
// - Reserved bits read zero, writes ignored
// - Third word bits 29:24 flag capture pins
// - Third word flags converter, comparator, pulse pins
// - Fourth word bits 4:0 flag five ports
// - Capability words are fixed and read-only
// - Wait field 15:2 resets to 0x1fff
// - Select bit one: reset; zero: interrupt
// - Filter on: wait, resample, then signal
// - Resample deasserted means noise: no brown-out event, noise status bit set
// - Filter off: report assertion at once
// - Wait counter counts beyond ten thousand
`timescale 1ns/1ps
`default_nettype none
module capability_and_brownout_ctrl (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    // APB answer
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Brown-out detector and oscillator period tick
    input  wire logic        brownout_detector,
    input  wire logic        internal_oscillator_tick,
    // Signalling to the controller
    output logic             brownout_reset_req,
    output logic             brownout_irq
);
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        reset_req_r;
    logic        irq_r;

    logic [13:0] brownout_wait_count_r;
    logic        brownout_signal_select_r;
    logic        brownout_filter_enable_r;
    logic        report_enable_r;
    logic [1:0]  irq_status_r;
    logic [1:0]  irq_status_nxt;
    logic [1:0]  irq_mask_r;

    logic        access;
    logic        done;
    logic        wr_done;
    logic        rd_done;
    logic        hit;
    logic [31:0] rd_value;
    logic [1:0]  irq_set;
    logic [1:0]  irq_clr;

    logic        detector_level;
    logic        confirm;
    logic        noise;
    logic        filt_busy;

    level_sync u_det_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (brownout_detector),
        .sync_out (detector_level)
    );

    brownout_filter u_filter (
        .pclk           (pclk),
        .presetn        (presetn),
        .report_enable  (report_enable_r),
        .filter_enable  (brownout_filter_enable_r),
        .wait_count     (brownout_wait_count_r),
        .detector_level (detector_level),
        .osc_tick       (internal_oscillator_tick),
        .confirm        (confirm),
        .noise          (noise),
        .busy           (filt_busy)
    );

    // One wait state: data is prepared before pready rises
    assign access  = psel & penable;
    assign done    = access & pready_r;
    assign wr_done = done & pwrite;
    assign rd_done = done & ~pwrite;

    always_comb begin
        hit      = 1'b1;
        rd_value = 32'h0;
        case (paddr)
            capability_brownout_pkg::OFS_CAP_TWO: begin
                rd_value = capability_brownout_pkg::CAP_TWO_VAL;
            end
            capability_brownout_pkg::OFS_CAP_THREE: begin
                rd_value = capability_brownout_pkg::CAP_THREE_VAL;
            end
            capability_brownout_pkg::OFS_CAP_FOUR: begin
                rd_value = capability_brownout_pkg::CAP_FOUR_VAL;
            end
            capability_brownout_pkg::OFS_BOR_CTRL: begin
                rd_value[15:2] = brownout_wait_count_r;
                rd_value[1]    = brownout_signal_select_r;
                rd_value[0]    = brownout_filter_enable_r;
            end
            capability_brownout_pkg::OFS_BOR_ENABLE: begin
                rd_value[0] = report_enable_r;
            end
            capability_brownout_pkg::OFS_IRQ_STATUS: begin
                rd_value[1:0] = irq_status_r;
            end
            capability_brownout_pkg::OFS_IRQ_MASK: begin
                rd_value[1:0] = irq_mask_r;
            end
            capability_brownout_pkg::OFS_FILT_STATE: begin
                rd_value[1] = detector_level;
                rd_value[0] = filt_busy;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // APB handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            if (access && !pready_r) begin
                pready_r  <= 1'b1;
                pslverr_r <= ~hit;
                prdata_r  <= pwrite ? 32'h0 : rd_value;
            end else begin
                pready_r  <= 1'b0;
                pslverr_r <= 1'b0;
                prdata_r  <= 32'h0;
            end
        end
    end

    // Brown-out control word; capability offsets take no write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_wait_count_r    <= capability_brownout_pkg::WAIT_RST;
            brownout_signal_select_r <= capability_brownout_pkg::SEL_RST;
            brownout_filter_enable_r <= capability_brownout_pkg::FILT_RST;
        end else if (wr_done &&
                     paddr == capability_brownout_pkg::OFS_BOR_CTRL) begin
            brownout_wait_count_r    <= pwdata[15:2];
            brownout_signal_select_r <= pwdata[1];
            brownout_filter_enable_r <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            report_enable_r <= capability_brownout_pkg::REPORT_RST;
        end else if (wr_done &&
                     paddr == capability_brownout_pkg::OFS_BOR_ENABLE) begin
            report_enable_r <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= capability_brownout_pkg::IRQ_MASK_RST;
        end else if (wr_done &&
                     paddr == capability_brownout_pkg::OFS_IRQ_MASK) begin
            irq_mask_r <= pwdata[1:0];
        end
    end

    // Sticky events; a set in the clearing read's cycle survives
    assign irq_set[capability_brownout_pkg::IRQ_BOR_BIT] =
        confirm & ~brownout_signal_select_r;
    assign irq_set[capability_brownout_pkg::IRQ_NOISE_BIT] = noise;
    assign irq_clr = (rd_done &&
                      paddr == capability_brownout_pkg::OFS_IRQ_STATUS) ?
                     2'h3 : 2'h0;
    assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= 2'h0;
            irq_r        <= 1'b0;
        end else begin
            irq_status_r <= irq_status_nxt;
            irq_r        <= |(irq_status_nxt & irq_mask_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_req_r <= 1'b0;
        end else begin
            reset_req_r <= confirm & brownout_signal_select_r;
        end
    end

    assign prdata             = prdata_r;
    assign pready             = pready_r;
    assign pslverr            = pslverr_r;
    assign brownout_reset_req = reset_req_r;
    assign brownout_irq       = irq_r;
endmodule
`default_nettype wire

// ===== design/capability_brownout_pkg.sv
// Register map, field layout and constants of the capability and brown-out block
package capability_brownout_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [11:0] OFS_CAP_TWO    = 12'h014;
    localparam logic [11:0] OFS_CAP_THREE  = 12'h018;
    localparam logic [11:0] OFS_CAP_FOUR   = 12'h01c;
    localparam logic [11:0] OFS_BOR_CTRL   = 12'h030;
    localparam logic [11:0] OFS_BOR_ENABLE = 12'h100;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h104;
    localparam logic [11:0] OFS_IRQ_MASK   = 12'h108;
    localparam logic [11:0] OFS_FILT_STATE = 12'h10c;

    // Fixed capability words; reserved positions read as zero
    localparam logic [31:0] CAP_TWO_VAL   = 32'h0107_0013;
    localparam logic [31:0] CAP_THREE_VAL = 32'h3f0f_01c3;
    localparam logic [31:0] CAP_FOUR_VAL  = 32'h0000_001f;

    // Brown-out control word layout
    localparam int unsigned WAIT_LSB   = 2;
    localparam int unsigned WAIT_MSB   = 15;
    localparam int unsigned WAIT_W     = 14;
    localparam int unsigned SEL_BIT    = 1;
    localparam int unsigned FILT_BIT   = 0;
    localparam int unsigned CTRL_W     = 16;
    localparam logic [13:0] WAIT_RST   = 14'h1fff;
    localparam logic        SEL_RST    = 1'b0;
    localparam logic        FILT_RST   = 1'b1;
    localparam logic        REPORT_RST = 1'b1;

    // Interrupt status and mask layout
    localparam int unsigned IRQ_W          = 2;
    localparam int unsigned IRQ_BOR_BIT    = 0;
    localparam int unsigned IRQ_NOISE_BIT  = 1;
    localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;

    // Filter states, Gray along idle -> wait
    typedef enum logic [1:0] {
        FILT_IDLE = 2'b00,
        FILT_WAIT = 2'b01
    } filt_state_e;

endpackage

// ===== design/level_sync.sv
// Two flip-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module level_sync (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Level
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;
    logic sync_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule
`default_nettype wire

// ===== design/brownout_filter.sv
// Brown-out wait-and-resample filter counting oscillator periods
`timescale 1ns/1ps
`default_nettype none
module brownout_filter (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Settings
    input  wire logic        report_enable,
    input  wire logic        filter_enable,
    input  wire logic [13:0] wait_count,
    // Detector and oscillator period tick
    input  wire logic        detector_level,
    input  wire logic        osc_tick,
    // Results
    output logic             confirm,
    output logic             noise,
    output logic             busy
);
    capability_brownout_pkg::filt_state_e state_r;
    logic [13:0] cnt_r;
    logic        level_d_r;
    logic        rise;
    logic        confirm_r;
    logic        noise_r;

    assign rise = detector_level & ~level_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_d_r <= 1'b0;
        end else begin
            level_d_r <= detector_level;
        end
    end

    // Further rises are ignored while a wait runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= capability_brownout_pkg::FILT_IDLE;
            cnt_r     <= 14'h0;
            confirm_r <= 1'b0;
            noise_r   <= 1'b0;
        end else begin
            confirm_r <= 1'b0;
            noise_r   <= 1'b0;
            case (state_r)
                capability_brownout_pkg::FILT_IDLE: begin
                    if (rise && report_enable) begin
                        if (filter_enable) begin
                            state_r <= capability_brownout_pkg::FILT_WAIT;
                            cnt_r   <= wait_count;
                        end else begin
                            confirm_r <= 1'b1;
                        end
                    end
                end
                capability_brownout_pkg::FILT_WAIT: begin
                    if (osc_tick) begin
                        if (cnt_r <= 14'h1) begin
                            state_r   <= capability_brownout_pkg::FILT_IDLE;
                            confirm_r <= detector_level;
                            noise_r   <= ~detector_level;
                        end else begin
                            cnt_r <= cnt_r - 14'h1;
                        end
                    end
                end
                default: begin
                    state_r <= capability_brownout_pkg::FILT_IDLE;
                end
            endcase
        end
    end

    assign confirm = confirm_r;
    assign noise   = noise_r;
    assign busy    = (state_r == capability_brownout_pkg::FILT_WAIT);
endmodule
`default_nettype wire

// ===== tb/brownout_source.sv
// Detector level and oscillator tick source
`timescale 1ns/1ps
`default_nettype none
module brownout_source #(
    parameter int TICK_DIV = 4
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Detector side
    output logic      detector,
    output logic      osc_tick
);
    int unsigned div_r;
    initial detector = 1'b0;
    // Oscillator runs free, unrelated to any frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 0;
        end else begin
            div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
        end
    end
    assign osc_tick = (div_r == TICK_DIV - 1);
    // Caller enters just after a rising edge
    task automatic trip(input int unsigned n);
        detector <= 1'b1;
        repeat (n) @(posedge pclk);
        detector <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/capability_brownout_checker.sv
// Port assertions for the capability and brown-out block
`timescale 1ns/1ps
`default_nettype none
module capability_brownout_checker (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Brown-out
    input wire logic        brownout_detector,
    input wire logic        brownout_reset_req,
    input wire logic        brownout_irq
);
    logic [3:0] since_hi;
    logic       rd;
    assign rd = pready && !pwrite;
    // Any signal needs the detector high shortly before
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_hi <= 4'hf;
        end else if (brownout_detector) begin
            since_hi <= 4'h0;
        end else if (since_hi != 4'hf) begin
            since_hi <= since_hi + 4'h1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    cap_two_a: assert property (rd && paddr == 12'h014 |->
        prdata == 32'h0107_0013) else $error("cap two word");
    cap_three_a: assert property (rd && paddr == 12'h018 |->
        prdata == 32'h3f0f_01c3) else $error("cap three word");
    cap_four_a: assert property (rd && paddr == 12'h01c |->
        prdata == 32'h0000_001f) else $error("cap four word");
    ctrl_reserved_a: assert property (rd && paddr == 12'h030 |->
        prdata[31:16] == 16'h0000) else $error("ctrl reserved");
    req_pulse_a: assert property (brownout_reset_req |=>
        !brownout_reset_req) else $error("reset req too long");
    req_cause_a: assert property (brownout_reset_req |->
        since_hi < 4'h8) else $error("reset req without detector");
    // A mask write may raise it too; bound holds for short waits only
    irq_cause_a: assert property ($rose(brownout_irq) &&
        !$past(pready && pwrite, 2) |-> since_hi < 4'h8)
        else $error("irq without detector");
    irq_clear_a: assert property ($fell(brownout_irq) |->
        $past(pready) || $past(pready, 2)) else $error("irq fell alone");
    cover property (brownout_reset_req);
    cover property ($rose(brownout_irq));
    cover property (pslverr);
endmodule
bind capability_and_brownout_ctrl capability_brownout_checker u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .brownout_detector(brownout_detector),
    .brownout_reset_req(brownout_reset_req),
    .brownout_irq(brownout_irq)
);
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the capability and brown-out block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        det;
    logic        tick;
    logic        req;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          err_total;
    int          checked;
    int          pulses;

    capability_and_brownout_ctrl DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .brownout_detector(det),
        .internal_oscillator_tick(tick), .brownout_reset_req(req),
        .brownout_irq(irq));
    brownout_source src (.pclk(pclk), .presetn(presetn),
        .detector(det), .osc_tick(tick));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (req === 1'b1)
            pulses <= pulses + 1;
    end

    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask
    // Entered just after a rising edge; pready is taken at the rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never drives psel in one step
        @(posedge pclk);
        if (n >= 20) begin
            err_total++;
            final_report();
        end
    endtask
    function automatic logic [31:0] cap_exp(input int i);
        return i == 0 ? 32'h0107_0013 : i == 1 ? 32'h3f0f_01c3 : 32'h1f;
    endfunction
    function automatic logic [31:0] ctrl_exp(input logic [31:0] d);
        return {16'h0000, d[15:0]};
    endfunction

    initial begin
        logic [31:0] v;
        logic [11:0] a;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        void'($urandom(43));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h030, 0);
        chk("ctrl reset", 32'h0000_7ffd, rd);
        for (int i = 0; i < 3; i++) begin
            a = 12'h014 + 12'(4 * i);
            apb(1, a, $urandom());
            apb(0, a, 0);
            chk("cap word", cap_exp(i), rd);
        end
        repeat (4) begin
            v = {16'h0, 16'($urandom())};
            apb(1, 12'h030, v);
            apb(0, 12'h030, 0);
            chk("ctrl rw", ctrl_exp(v), rd);
        end
        apb(0, 12'h200, 0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test registers done");
        apb(1, 12'h030, 32'h0000_0009);
        for (int m = 1; m >= 0; m--) begin
            apb(1, 12'h108, 32'(m));
            src.trip(30);
            repeat (20) @(posedge pclk);
            chk("irq level", 32'(m), {31'h0, irq});
            apb(0, 12'h104, 0);
            chk("status event", 32'h1, rd);
            repeat (2) @(posedge pclk);
            chk("irq clear", 32'h0, {31'h0, irq});
        end
        @(posedge pclk);
        src.trip(3);
        repeat (30) @(posedge pclk);
        apb(0, 12'h104, 0);
        chk("status noise", 32'h2, rd);
        $display("test filter done");
        v = 32'h0000_0002;
        for (int k = 1; k <= 2; k++) begin
            apb(1, 12'h030, v);
            src.trip(30);
            repeat (20) @(posedge pclk);
            chk("reset pulses", 32'(k), 32'(pulses));
            apb(0, 12'h104, 0);
            chk("status none", 32'h0, rd);
            v = 32'h0000_000b;
        end
        apb(1, 12'h100, 32'h0);
        src.trip(30);
        repeat (20) @(posedge pclk);
        chk("reset disabled", 32'h2, 32'(pulses));
        apb(0, 12'h100, 0);
        chk("enable reg", 32'h0, rd);
        $display("test reset done");
        final_report();
    end
endmodule
`default_nettype wire
